// *** src/eip_error_pending_mask.sv ***
// pending capture and mask logic for the 32 internal error interrupts
`timescale 1ns/1ns
`default_nettype none
`include "eip_regs.svh"

module eip_error_pending_mask
    import eip_pkg::*;
(
    // clock, reset, enable
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  wire logic           clk_en,
    // register port, byte wide, same clock domain
    input  wire eip_host_req_t  host_req,
    output logic [7:0]          host_rdata,
    // error sources, asynchronous to clk
    input  wire logic [15:0]    system_error_source,
    input  wire eip_clock_err_t clock_error_source,
    // controller mode: high when interrupt controller disabled
    input  wire logic           ctrl_disabled,
    // fault outputs
    output logic                system_fault_output,
    output logic                timing_fault_output
);

    // ======================================================
    // source synchronisers and event detect
    logic [15:0] sys_meta;      // first stage, read by second only
    logic [15:0] sys_sync;      // second stage
    logic [15:0] sys_prev;      // for rising-edge detect
    logic [15:0] clk_meta;
    logic [15:0] clk_sync;
    logic [15:0] clk_prev;
    logic [15:0] clk_raw;       // struct flattened to bit order

    // explicit mapping keeps the bit positions visible
    assign clk_raw[`EIP_CLK_ALOOP1]     = clock_error_source.analog_loop_one;
    assign clk_raw[`EIP_CLK_DLOOP2]     = clock_error_source.digital_loop_two;
    assign clk_raw[`EIP_CLK_DLOOP1]     = clock_error_source.digital_loop_one;
    assign clk_raw[`EIP_CLK_NETREF2]    = clock_error_source.netref2;
    assign clk_raw[`EIP_CLK_NETREF1]    = clock_error_source.netref1;
    assign clk_raw[`EIP_CLK_FRAME_COMP] = clock_error_source.compat_frame_ref;
    assign clk_raw[`EIP_CLK_FRAME_B]    = clock_error_source.frame_b;
    assign clk_raw[`EIP_CLK_FRAME_A]    = clock_error_source.frame_a;
    assign clk_raw[`EIP_CLK_SCLK_X2]    = clock_error_source.serial_bus_double_clock;
    assign clk_raw[`EIP_CLK_SCLK]       = clock_error_source.serial_bus_clock;
    assign clk_raw[`EIP_CLK_C2]         = clock_error_source.compat_2m_clock;
    assign clk_raw[`EIP_CLK_C4]         = clock_error_source.compat_4m_clock;
    assign clk_raw[`EIP_CLK_C16_NEG]    = clock_error_source.compat_16m_clock_neg;
    assign clk_raw[`EIP_CLK_C16_POS]    = clock_error_source.compat_16m_clock_pos;
    assign clk_raw[`EIP_CLK_C8_B]       = clock_error_source.c8_b;
    assign clk_raw[`EIP_CLK_C8_A]       = clock_error_source.c8_a;

    // two-flop sync plus one history stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_meta <= `EIP_PEND_RESET;
            sys_sync <= `EIP_PEND_RESET;
            sys_prev <= `EIP_PEND_RESET;
            clk_meta <= `EIP_PEND_RESET;
            clk_sync <= `EIP_PEND_RESET;
            clk_prev <= `EIP_PEND_RESET;
        end
        else if (clk_en)
        begin
            sys_meta <= system_error_source;
            sys_sync <= sys_meta;
            sys_prev <= sys_sync;
            clk_meta <= clk_raw;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
        end
    end

    // rising edge is one event; a stuck-high source fires once only,
    // so a clear is not immediately undone by a lingering level
    wire [15:0] sys_event = sys_sync & ~sys_prev;
    wire [15:0] clk_event = clk_sync & ~clk_prev;

    // ======================================================
    // address decode
    function automatic eip_sel_t decode_addr(input logic [19:0] a);
        case (a)
            `EIP_ADDR_SYS_PEND_LO: decode_addr = EIP_SEL_SPL;
            `EIP_ADDR_SYS_PEND_HI: decode_addr = EIP_SEL_SPH;
            `EIP_ADDR_SYS_EN_LO:   decode_addr = EIP_SEL_SEL;
            `EIP_ADDR_SYS_EN_HI:   decode_addr = EIP_SEL_SEH;
            `EIP_ADDR_CLK_PEND_LO: decode_addr = EIP_SEL_CPL;
            `EIP_ADDR_CLK_PEND_HI: decode_addr = EIP_SEL_CPH;
            `EIP_ADDR_CLK_EN_LO:   decode_addr = EIP_SEL_CEL;
            `EIP_ADDR_CLK_EN_HI:   decode_addr = EIP_SEL_CEH;
            default:               decode_addr = EIP_SEL_NONE;
        endcase
    endfunction

    wire eip_sel_t sel = decode_addr(host_req.addr);
    wire           wr  = host_req.wr & clk_en;

    // ======================================================
    // write strobes widened to 16-bit masks
    wire [15:0] wdata_lo = {8'h00, host_req.wdata};
    wire [15:0] wdata_hi = {host_req.wdata, 8'h00};

    wire [15:0] sys_clr = (wr && sel == EIP_SEL_SPL) ? wdata_lo :
                          (wr && sel == EIP_SEL_SPH) ? wdata_hi :
                          16'h0000;
    wire [15:0] clk_clr = (wr && sel == EIP_SEL_CPL) ? wdata_lo :
                          (wr && sel == EIP_SEL_CPH) ? wdata_hi :
                          16'h0000;

    // ======================================================
    // pending and enable storage
    logic [15:0] sys_pend;   // system_pending_bit_0 .. _15
    logic [15:0] clk_pend;   // clock_pending_bit_0 .. _15
    logic [15:0] sys_en;     // system_enable_bit_0 .. _15
    logic [15:0] clk_en_r;   // clock_enable_bit_0 .. _15

    // masked event sets, clear only where written one; set wins
    wire [15:0] next_sys_pend = (sys_pend & ~sys_clr) | (sys_event & sys_en);
    wire [15:0] next_clk_pend = (clk_pend & ~clk_clr) | (clk_event & clk_en_r);

    // pending bits, reset to none pending
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_pend <= `EIP_PEND_RESET;
            clk_pend <= `EIP_PEND_RESET;
        end
        else if (clk_en)
        begin
            sys_pend <= next_sys_pend;
            clk_pend <= next_clk_pend;
        end
    end

    // enable bytes, plain storage; pending bits untouched here
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_en   <= `EIP_EN_RESET;
            clk_en_r <= `EIP_EN_RESET;
        end
        else if (wr)
        begin
            case (sel)
                EIP_SEL_SEL: sys_en[`EIP_LO_MSB:0] <= host_req.wdata;
                EIP_SEL_SEH: sys_en[`EIP_HI_MSB:`EIP_HI_LSB] <= host_req.wdata;
                EIP_SEL_CEL: clk_en_r[`EIP_LO_MSB:0] <= host_req.wdata;
                EIP_SEL_CEH: clk_en_r[`EIP_HI_MSB:`EIP_HI_LSB] <= host_req.wdata;
                default:     sys_en <= sys_en;  // pending and unmapped: no enable change
            endcase
        end
    end

    // ======================================================
    // read mux, registered data output
    function automatic logic [7:0] read_byte(input eip_sel_t s,
                                             input logic [15:0] sp,
                                             input logic [15:0] se,
                                             input logic [15:0] cp,
                                             input logic [15:0] ce);
        case (s)
            EIP_SEL_SPL: read_byte = sp[`EIP_LO_MSB:0];
            EIP_SEL_SPH: read_byte = sp[`EIP_HI_MSB:`EIP_HI_LSB];
            EIP_SEL_SEL: read_byte = se[`EIP_LO_MSB:0];
            EIP_SEL_SEH: read_byte = se[`EIP_HI_MSB:`EIP_HI_LSB];
            EIP_SEL_CPL: read_byte = cp[`EIP_LO_MSB:0];
            EIP_SEL_CPH: read_byte = cp[`EIP_HI_MSB:`EIP_HI_LSB];
            EIP_SEL_CEL: read_byte = ce[`EIP_LO_MSB:0];
            EIP_SEL_CEH: read_byte = ce[`EIP_HI_MSB:`EIP_HI_LSB];
            default:     read_byte = `EIP_RDATA_RESET;  // unmapped reads zero
        endcase
    endfunction

    wire [7:0] next_rdata = read_byte(sel, sys_pend, sys_en, clk_pend, clk_en_r);

    // data is captured on the read cycle, valid the cycle after
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            host_rdata <= `EIP_RDATA_RESET;
        else if (clk_en && host_req.rd)
            host_rdata <= next_rdata;
    end

    // ======================================================
    // fault outputs in disabled-controller mode
    // other modes belong to the arbiter, so these stay low there
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            system_fault_output <= 1'b0;
            timing_fault_output <= 1'b0;
        end
        else if (clk_en)
        begin
            system_fault_output <= ctrl_disabled & (|next_sys_pend);
            timing_fault_output <= ctrl_disabled & (|next_clk_pend);
        end
    end

endmodule
`default_nettype wire

// *** src/eip_regs.svh ***
// register map, field positions and reset values of the error pending/mask block
`ifndef EIP_REGS_SVH
`define EIP_REGS_SVH

// ==========================================================
// byte addresses
`define EIP_ADDR_SYS_PEND_LO 20'h0_0608
`define EIP_ADDR_SYS_PEND_HI 20'h0_0609
`define EIP_ADDR_SYS_EN_LO   20'h0_060A
`define EIP_ADDR_SYS_EN_HI   20'h0_060B
`define EIP_ADDR_CLK_PEND_LO 20'h0_060C
`define EIP_ADDR_CLK_PEND_HI 20'h0_060D
`define EIP_ADDR_CLK_EN_LO   20'h0_060E
`define EIP_ADDR_CLK_EN_HI   20'h0_060F

// ==========================================================
// reset values and fields
`define EIP_PEND_RESET  16'h0000
`define EIP_EN_RESET    16'h0000
`define EIP_RDATA_RESET 8'h00
`define EIP_LO_MSB      7
`define EIP_HI_LSB      8
`define EIP_HI_MSB      15

// ==========================================================
// clock error source positions
`define EIP_CLK_C8_A       0
`define EIP_CLK_C8_B       1
`define EIP_CLK_C16_POS    2
`define EIP_CLK_C16_NEG    3
`define EIP_CLK_C4         4
`define EIP_CLK_C2         5
`define EIP_CLK_SCLK       6
`define EIP_CLK_SCLK_X2    7
`define EIP_CLK_FRAME_A    8
`define EIP_CLK_FRAME_B    9
`define EIP_CLK_FRAME_COMP 10
`define EIP_CLK_NETREF1    11
`define EIP_CLK_NETREF2    12
`define EIP_CLK_DLOOP1     13
`define EIP_CLK_DLOOP2     14
`define EIP_CLK_ALOOP1     15

`endif

// *** src/eip_pkg.sv ***
// types shared by the error pending/mask block
package eip_pkg;

    // ======================================================
    // named clock error inputs
    typedef struct packed {
        logic analog_loop_one;      // failsafe reference error
        logic digital_loop_two;     // sync input error
        logic digital_loop_one;     // sync input error
        logic netref2;
        logic netref1;
        logic compat_frame_ref;
        logic frame_b;
        logic frame_a;
        logic serial_bus_double_clock;
        logic serial_bus_clock;
        logic compat_2m_clock;
        logic compat_4m_clock;
        logic compat_16m_clock_neg;
        logic compat_16m_clock_pos;
        logic c8_b;
        logic c8_a;
    } eip_clock_err_t;

    // ======================================================
    // host byte access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } eip_host_req_t;

    // register select
    typedef enum logic [3:0] {
        EIP_SEL_NONE = 4'b0000,
        EIP_SEL_SPL  = 4'b0001,
        EIP_SEL_SPH  = 4'b0010,
        EIP_SEL_SEL  = 4'b0011,
        EIP_SEL_SEH  = 4'b0100,
        EIP_SEL_CPL  = 4'b0101,
        EIP_SEL_CPH  = 4'b0110,
        EIP_SEL_CEL  = 4'b0111,
        EIP_SEL_CEH  = 4'b1000
    } eip_sel_t;

endpackage

// *** verification/eip_error_pending_mask_properties.sv ***
// port-level assertions for the error pending/mask block
`timescale 1ns/1ns
`default_nettype none
module eip_chk
    import eip_pkg::*;
(
    // clock and reset
    input wire logic           clk,
    input wire logic           arst_n,
    input wire logic           clk_en,
    // host port
    input wire eip_host_req_t  host_req,
    input wire logic [7:0]     host_rdata,
    // sources and faults
    input wire logic [15:0]    system_error_source,
    input wire eip_clock_err_t clock_error_source,
    input wire logic           ctrl_disabled,
    input wire logic           system_fault_output,
    input wire logic           timing_fault_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ====================================
    // enable shadow, mirrored from taken writes
    logic [15:0] se;                             // system enables
    logic [15:0] ce;                             // clock enables
    wire  [19:0] a       = host_req.addr;
    wire         rd      = clk_en && host_req.rd;
    wire         map     = a[19:3] == 17'h0_00c1; // 0x608..0x60f
    wire         we      = clk_en && host_req.wr && map && a[1];
    wire  [15:0] ew      = a[2] ? ce : se;
    wire  [7:0]  eb      = a[0] ? ew[15:8] : ew[7:0];
    wire  [15:0] next_ew = a[0] ? {host_req.wdata, ew[7:0]} : {ew[15:8], host_req.wdata};
    wire  [15:0] cs      = clock_error_source;
    // shadow follows writes only, never events
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            se <= 16'h0000;
            ce <= 16'h0000;
        end
        else if (we && !a[2])
            se <= next_ew;
        else if (we)
            ce <= next_ew;
    end
    // ====================================
    // an unmasked rising source while the controller is off
    sequence s_sys_rise;
        clk_en && ctrl_disabled && |(system_error_source & ~$past(system_error_source) & se);
    endsequence
    sequence s_clk_rise;
        clk_en && ctrl_disabled && |(cs & ~$past(cs) & ce);
    endsequence
    a_sys_event_fault: assert property (s_sys_rise |-> ##[1:4]
        (system_fault_output || !ctrl_disabled)) else $error("system fault late");
    a_clk_event_fault: assert property (s_clk_rise |-> ##[1:4]
        (timing_fault_output || !ctrl_disabled)) else $error("timing fault late");
    a_sys_fault_off: assert property (clk_en && !ctrl_disabled |=>
        !system_fault_output) else $error("system fault while enabled");
    a_clk_fault_off: assert property (clk_en && !ctrl_disabled |=>
        !timing_fault_output) else $error("timing fault while enabled");
    a_sys_fault_hold: assert property (system_fault_output && ctrl_disabled
        && !host_req.wr |=> system_fault_output) else $error("system fault dropped");
    a_clk_fault_hold: assert property (timing_fault_output && ctrl_disabled
        && !host_req.wr |=> timing_fault_output) else $error("timing fault dropped");
    a_unmapped_zero: assert property (rd && !map |=> host_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_stands: assert property (!rd |=> $stable(host_rdata))
        else $error("read data moved");
    a_enable_readback: assert property (rd && map && a[1] |=> host_rdata == $past(eb))
        else $error("enable readback wrong");
endmodule
bind eip_error_pending_mask eip_chk i_chk (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .host_req(host_req), .host_rdata(host_rdata), .system_error_source(system_error_source),
    .clock_error_source(clock_error_source), .ctrl_disabled(ctrl_disabled),
    .system_fault_output(system_fault_output), .timing_fault_output(timing_fault_output));
`default_nettype wire

// *** verification/eip_error_pending_mask_tb_top.sv ***
// self-checking bench for the error pending/mask block
`timescale 1ns/1ns
`default_nettype none
module eip_error_pending_mask_tb_top
    import eip_pkg::*;
;
    // ====================================
    // design signals and score counters
    logic           clk;
    logic           arst_n;
    logic           clk_en;
    eip_host_req_t  host_req;
    logic [7:0]     host_rdata;
    logic [15:0]    sys_src;
    eip_clock_err_t clk_src;
    logic           ctrl_disabled;
    logic           sys_f;
    logic           tim_f;
    int             n_mismatch;
    int             checks_done;
    logic [19:0]    ea [4] = '{20'h0_060a, 20'h0_060b, 20'h0_060e, 20'h0_060f};
    logic [7:0]     ed [4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
    // 10 MHz clock
    always #50 clk = ~clk;
    eip_error_pending_mask i_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .host_req(host_req), .host_rdata(host_rdata), .system_error_source(sys_src),
        .clock_error_source(clk_src), .ctrl_disabled(ctrl_disabled),
        .system_fault_output(sys_f), .timing_fault_output(tim_f));
    // ====================================
    // compare, host access and closing tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // idle cycle after each access keeps strobe changes apart
    task automatic acc(input logic r, input logic [19:0] ad, input logic [7:0] d);
        host_req = '{rd: r, wr: !r, addr: ad, wdata: d};
        ticks(1);
        host_req = '0;
        ticks(1);
    endtask
    task automatic rd(input logic [19:0] ad, input logic [7:0] exp);
        acc(1'b1, ad, 8'h00);
        chk(host_rdata, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ====================================
    // main sequence
    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        clk_en = 1'b1;
        host_req = '0;
        sys_src = 16'h0000;
        clk_src = '0;
        ctrl_disabled = 1'b1;
        n_mismatch = 0;
        checks_done = 0;
        ticks(6);
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++)
            rd(20'h0_0608 + 20'(i), 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
            acc(1'b0, ea[i], ed[i]);
        acc(1'b0, 20'h0_0610, 8'hff);
        for (int i = 0; i < 4; i++)
            rd(ea[i], ed[i]);
        rd(20'h0_0610, 8'h00);
        clk_en = 1'b0;
        acc(1'b0, ea[0], 8'h00);
        clk_en = 1'b1;
        rd(ea[0], 8'ha5);
        $display("test enables done");
        for (int i = 0; i < 4; i++)
            acc(1'b0, ea[i], 8'hff);
        sys_src = 16'h8001;
        clk_src = '{analog_loop_one: 1'b1, digital_loop_one: 1'b1, netref2: 1'b1,
                    c8_a: 1'b1, default: 1'b0};
        ticks(5);
        rd(20'h0_0608, 8'h01);
        rd(20'h0_0609, 8'h80);
        rd(20'h0_060c, 8'h01);
        rd(20'h0_060d, 8'hb0);
        chk({7'h00, sys_f}, 8'h01);
        chk({7'h00, tim_f}, 8'h01);
        $display("test capture done");
        acc(1'b0, 20'h0_0608, 8'h00);
        rd(20'h0_0608, 8'h01);
        acc(1'b0, 20'h0_0608, 8'h01);
        rd(20'h0_0608, 8'h00);
        chk({7'h00, sys_f}, 8'h01);
        acc(1'b0, 20'h0_0609, 8'hff);
        chk({7'h00, sys_f}, 8'h00);
        acc(1'b0, 20'h0_060d, 8'h30);
        acc(1'b0, 20'h0_060f, 8'h00);
        rd(20'h0_060d, 8'h80);
        $display("test clearing done");
        sys_src = 16'h0000;
        ticks(3);
        acc(1'b0, 20'h0_060a, 8'h00);
        sys_src = 16'h0001;
        ticks(5);
        rd(20'h0_0608, 8'h00);
        acc(1'b0, 20'h0_060a, 8'h01);
        ticks(3);
        rd(20'h0_0608, 8'h00);
        chk({7'h00, sys_f}, 8'h00);
        $display("test masking done");
        ctrl_disabled = 1'b0;
        ticks(2);
        chk({7'h00, tim_f}, 8'h00);
        ctrl_disabled = 1'b1;
        ticks(2);
        chk({7'h00, tim_f}, 8'h01);
        $display("test mode done");
        complete_run();
    end
endmodule
`default_nettype wire
